/* File: src/wdt_regs.svh */
// address map, key values, option field positions and timing counts
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// addresses on the cpu access port
`define WDT_OPT_ADDR     20'h000c0
`define WDT_KEY_ADDR     20'hfffab

// key register values
`define WDT_KEY_VALUE    8'hac
`define WDT_KEY_RD_ON    8'h9a
`define WDT_KEY_RD_OFF   8'h1a

// option byte field positions
`define WDT_OPT_IRQ_BIT  7
`define WDT_OPT_WIN_HI   6
`define WDT_OPT_WIN_LO   5
`define WDT_OPT_RUN_BIT  4
`define WDT_OPT_OVF_HI   3
`define WDT_OPT_OVF_LO   1
`define WDT_OPT_STBY_BIT 0

// window selection codes
`define WDT_WIN_50       2'h1
`define WDT_WIN_75       2'h2

// bit of the reset-cause register owned by the watchdog
`define WDT_CAUSE_BIT    4

// counter width
`define WDT_CNT_W        17

// clock rates and the derived low-speed tick divider
`define WDT_SYS_CLK_HZ   20000000
`define WDT_LSO_HZ       15000
`define WDT_LSO_DIV      (`WDT_SYS_CLK_HZ / `WDT_LSO_HZ)

`endif

/* File: src/wdt_pkg.sv */
// types shared by the watchdog modules
`include "wdt_regs.svh"

package wdt_pkg;

	typedef enum logic [1:0] {
		ST_LOAD,
		ST_RUN,
		ST_OFF
	} wdt_state_e;

	typedef struct packed {
		wdt_state_e              state;
		logic [7:0]              opt;
		logic [`WDT_CNT_W-1:0]   cnt;
		logic                    clr_pend;
		logic                    first_done;
		logic                    irq_done;
		logic                    hs_prev;
		logic                    rst_req;
		logic                    irq;
		logic                    cause;
		logic [7:0]              rdata;
	} wdt_core_s;

	typedef struct packed {
		logic [15:0] cnt;
	} wdt_tick_s;

endpackage

/* File: src/wdt_tick.sv */
// divider that makes the low-speed oscillator tick and half-tick enables
`timescale 1ns/1ps

module wdt_tick #(
	parameter int DIV = 1333
) (
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	output logic      tick_o,
	output logic      half_o
);
	import wdt_pkg::*;

	wdt_tick_s tick_reg;
	wdt_tick_s tick_next;

	// free-running count, wraps once per low-speed period
	always_comb begin
		tick_next = tick_reg;
		if (tick_reg.cnt == 16'(DIV - 1)) begin
			tick_next.cnt = 16'h0000;
		end else begin
			tick_next.cnt = tick_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tick_reg <= '0;
		end else begin
			tick_reg <= tick_next;
		end
	end

	// half fires mid-period, so it lags each tick by half a period
	assign tick_o = (tick_reg.cnt == 16'(DIV - 1));
	assign half_o = (tick_reg.cnt == 16'(DIV / 2 - 1));

endmodule

/* File: src/wdt_top.sv */
// windowed watchdog timer core with key register and option byte
`timescale 1ns/1ps
`include "wdt_regs.svh"

module wdt_top #(
	parameter int LSO_DIV = `WDT_LSO_DIV
) (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  opt_byte_i,
	input  wire logic [19:0] cpu_addr_i,
	input  wire logic        cpu_wr_i,
	input  wire logic        cpu_rd_i,
	input  wire logic        cpu_bit_op_i,
	input  wire logic [7:0]  cpu_wdata_i,
	input  wire logic        halt_i,
	input  wire logic        stop_i,
	input  wire logic        snooze_i,
	input  wire logic        cause_clr_i,
	output logic [7:0]       cpu_rdata_o,
	output logic             wdg_reset_req_o,
	output logic             interval_irq_o,
	output logic [7:0]       reset_cause_register_o
);
	import wdt_pkg::*;

	localparam int CW = `WDT_CNT_W;
	localparam wdt_core_s RST_VAL = '{state: ST_LOAD, default: '0};

	wdt_core_s       core_reg;
	wdt_core_s       core_next;

	logic            lso_tick;
	logic            lso_half;
	logic [4:0]      ovf_shift;
	logic [CW-1:0]   ovf_len;
	logic [CW-1:0]   ovf_last;
	logic [CW-1:0]   win_limit;
	logic [CW-1:0]   irq_pt;
	logic            win_closed;
	logic            frozen;
	logic            hs_now;
	logic            hs_exit;
	logic            key_hit;
	logic            key_val_ok;
	logic            bad_bit;
	logic            bad_val;
	logic            bad_win;
	logic            key_ok;
	logic            cnt_step;
	logic            ovf_hit;
	logic            irq_hit;
	logic            err;
	logic [1:0]      win_sel;
	logic [7:0]      opt_now;

	// low-speed oscillator modelled as a tick enable on the system clock
	wdt_tick #(
		.DIV (LSO_DIV)
	) u_tick (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_o    (lso_tick),
		.half_o    (lso_half)
	);

	// overflow select to power of two
	function automatic logic [4:0] ovf_bits(input logic [2:0] sel);
		logic [4:0] b;
		b = 5'h06;
		case (sel)
			3'h0: b = 5'h06;
			3'h1: b = 5'h07;
			3'h2: b = 5'h08;
			3'h3: b = 5'h09;
			3'h4: b = 5'h0b;
			3'h5: b = 5'h0d;
			3'h6: b = 5'h0e;
			default: b = 5'h10;
		endcase
		return b;
	endfunction

	// option decode: overflow length and interval point
	assign ovf_shift = ovf_bits(core_reg.opt[`WDT_OPT_OVF_HI:`WDT_OPT_OVF_LO]);
	assign ovf_len   = CW'(1) << ovf_shift;
	assign ovf_last  = ovf_len - CW'(1);
	assign irq_pt    = ovf_len - (ovf_len >> 2);
	assign win_sel   = core_reg.opt[`WDT_OPT_WIN_HI:`WDT_OPT_WIN_LO];

	// read view of the option: the strap itself until it has been caught
	assign opt_now   = (core_reg.state == ST_LOAD) ? opt_byte_i :
	                   core_reg.opt;

	// closed part of the window; prohibited code falls back to fully open
	always_comb begin
		win_limit = '0;
		if (core_reg.opt[`WDT_OPT_STBY_BIT]) begin
			case (win_sel)
				`WDT_WIN_50: win_limit = ovf_len >> 1;
				`WDT_WIN_75: win_limit = ovf_len >> 2;
				default:     win_limit = '0;
			endcase
		end
	end

	assign win_closed = (core_reg.cnt < win_limit);

	// standby handling
	assign hs_now  = halt_i | stop_i;
	assign frozen  = !core_reg.opt[`WDT_OPT_STBY_BIT] &&
	                 (hs_now || snooze_i);
	assign hs_exit = core_reg.hs_prev && !hs_now &&
	                 !core_reg.opt[`WDT_OPT_STBY_BIT];

	// key register write checks, bit access checked before the value
	assign key_hit    = cpu_wr_i && (cpu_addr_i == `WDT_KEY_ADDR);
	assign key_val_ok = (cpu_wdata_i == `WDT_KEY_VALUE);
	assign bad_bit    = key_hit && cpu_bit_op_i;
	assign bad_val    = key_hit && !cpu_bit_op_i && !key_val_ok;
	assign bad_win    = key_hit && !cpu_bit_op_i && key_val_ok &&
	                    core_reg.first_done && win_closed;
	assign key_ok     = key_hit && !cpu_bit_op_i && key_val_ok && !bad_win;

	// a pending or same-cycle clear masks the overflow: a late key saves us
	assign cnt_step = lso_tick && (core_reg.state == ST_RUN) && !frozen;
	assign ovf_hit  = cnt_step && !core_reg.clr_pend && !key_ok &&
	                  (core_reg.cnt == ovf_last);
	// only the exact count fires the irq: no stray irq after a clear
	assign irq_hit  = core_reg.opt[`WDT_OPT_IRQ_BIT] && lso_half &&
	                  (core_reg.state == ST_RUN) && !frozen &&
	                  !core_reg.irq_done && (core_reg.cnt == irq_pt);
	assign err      = bad_bit | bad_val | bad_win | ovf_hit;

	// next-state logic for the whole core
	always_comb begin
		core_next         = core_reg;
		core_next.rst_req = 1'b0;
		core_next.irq     = 1'b0;
		core_next.rdata   = 8'h00;
		core_next.hs_prev = hs_now;
		case (core_reg.state)
			ST_LOAD: begin
				// option byte is caught one cycle after reset release
				core_next.opt   = opt_byte_i;
				core_next.state = opt_byte_i[`WDT_OPT_RUN_BIT] ?
				                  ST_RUN : ST_OFF;
			end
			ST_RUN: begin
				if (hs_exit) begin
					core_next.cnt      = '0;
					core_next.clr_pend = 1'b0;
					core_next.irq_done = 1'b0;
				end else if (cnt_step) begin
					if (core_reg.clr_pend) begin
						core_next.cnt      = '0;
						core_next.clr_pend = 1'b0;
						core_next.irq_done = 1'b0;
					end else begin
						core_next.cnt = core_reg.cnt + CW'(1);
					end
				end
				if (irq_hit) begin
					core_next.irq      = 1'b1;
					core_next.irq_done = 1'b1;
				end
			end
			ST_OFF: begin
				// counting disabled by the option byte; checks still apply
				core_next.cnt = '0;
			end
			default: begin
				core_next.state = ST_LOAD;
			end
		endcase
		// a valid key only arms the clear; the next tick carries it out
		if (key_ok) begin
			core_next.clr_pend   = 1'b1;
			core_next.first_done = 1'b1;
		end
		// cause flag: set wins over a clear in the same cycle
		if (cause_clr_i) begin
			core_next.cause = 1'b0;
		end
		if (err) begin
			core_next.cause      = 1'b1;
			core_next.rst_req    = 1'b1;
			core_next.state      = ST_LOAD;
			core_next.cnt        = '0;
			core_next.clr_pend   = 1'b0;
			core_next.first_done = 1'b0;
			core_next.irq_done   = 1'b0;
		end
		// reads; the key register never echoes what was written
		if (cpu_rd_i && (cpu_addr_i == `WDT_KEY_ADDR)) begin
			core_next.rdata = opt_now[`WDT_OPT_RUN_BIT] ?
			                  `WDT_KEY_RD_ON : `WDT_KEY_RD_OFF;
		end else if (cpu_rd_i && (cpu_addr_i == `WDT_OPT_ADDR)) begin
			core_next.rdata = opt_now;
		end
	end

	// single state register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			core_reg <= RST_VAL;
		end else begin
			core_reg <= core_next;
		end
	end

	// outputs straight from the state register
	assign cpu_rdata_o     = core_reg.rdata;
	assign wdg_reset_req_o = core_reg.rst_req;
	assign interval_irq_o  = core_reg.irq;
	always_comb begin
		reset_cause_register_o = 8'h00;
		reset_cause_register_o[`WDT_CAUSE_BIT] = core_reg.cause;
	end

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_tick_only;
		!lso_tick && !err && !hs_exit && core_reg.state != ST_LOAD
		|=> $stable(core_reg.cnt);
	endproperty
	a_tick_only: assert property (p_tick_only)
		else $error("counter moved without a low-speed tick");

	property p_overflow;
		ovf_hit |=> wdg_reset_req_o && core_reg.cnt == '0;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow did not request reset");

	property p_bit_op;
		key_hit && cpu_bit_op_i |=> wdg_reset_req_o;
	endproperty
	a_bit_op: assert property (p_bit_op)
		else $error("bit access to key did not reset");

	property p_bad_key;
		key_hit && !cpu_bit_op_i && cpu_wdata_i != 8'hac
		|=> wdg_reset_req_o ##1 !wdg_reset_req_o;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("wrong key did not give one reset pulse");

	property p_closed;
		key_hit && !cpu_bit_op_i && key_val_ok &&
		core_reg.first_done && core_reg.cnt < win_limit
		|=> wdg_reset_req_o;
	endproperty
	a_closed: assert property (p_closed)
		else $error("key in closed window did not reset");

	property p_cause;
		wdg_reset_req_o |-> reset_cause_register_o[4];
	endproperty
	a_cause: assert property (p_cause)
		else $error("reset cause flag not set");

	property p_irq;
		interval_irq_o |-> $past(core_reg.cnt) == irq_pt &&
		core_reg.opt[7] && $past(lso_half);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interval irq at wrong count");

	property p_clear;
		cnt_step && core_reg.clr_pend && !err && !hs_exit
		|=> core_reg.cnt == '0 && core_reg.clr_pend == $past(key_ok);
	endproperty
	a_clear: assert property (p_clear)
		else $error("pending clear not applied on tick");

	property p_key_read;
		cpu_rd_i && cpu_addr_i == 20'hfffab
		|=> cpu_rdata_o == (core_reg.opt[4] ? 8'h9a : 8'h1a);
	endproperty
	a_key_read: assert property (p_key_read)
		else $error("key register read wrong value");

	property p_off;
		core_reg.state == ST_OFF && !err |=> core_reg.cnt == '0;
	endproperty
	a_off: assert property (p_off)
		else $error("counter runs while disabled");

	property p_frozen;
		frozen && core_reg.state == ST_RUN && !err && !key_ok
		|=> $past(hs_exit) ? (core_reg.cnt == '0 && !core_reg.clr_pend) :
		    ($stable(core_reg.cnt) && $stable(core_reg.clr_pend));
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("counter moved in standby");

	property p_late_key;
		key_ok && core_reg.state == ST_RUN && !frozen
		|=> !wdg_reset_req_o ##1 !wdg_reset_req_o;
	endproperty
	a_late_key: assert property (p_late_key)
		else $error("valid key did not prevent reset");

	property p_first_key;
		key_hit && !cpu_bit_op_i && key_val_ok && !core_reg.first_done
		|=> !wdg_reset_req_o;
	endproperty
	a_first_key: assert property (p_first_key)
		else $error("first key after reset was refused");

	c_overflow: cover property (ovf_hit);
	c_restart:  cover property (key_ok && core_reg.first_done);
	c_irq:      cover property (interval_irq_o);
	c_closed:   cover property (bad_win);
	c_win75:    cover property (bad_win && win_sel == `WDT_WIN_75);

endmodule

/* File: tb/wdt_top_tb.sv */
// self-checking bench for the windowed watchdog core
`timescale 1ns/1ps
`include "wdt_regs.svh"

module windowed_watchdog_timer_tb_top;
	// short tick divider keeps overflow runs brief
	localparam int DIV = 8;
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  opt       = 8'h00;
	logic [19:0] addr      = 20'h00000;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic        bop       = 1'b0;
	logic [7:0]  wdat      = 8'h00;
	logic        halt      = 1'b0;
	logic        stp       = 1'b0;
	logic        snz       = 1'b0;
	logic        cclr      = 1'b0;
	logic [7:0]  rdat;
	logic        req;
	logic        irq;
	logic [7:0]  cause;
	int          mismatches  = 0;
	int          comparisons = 0;
	int          n;
	int          n1;
	int          t;
	logic        hit;
	int          ex[4] = '{7, 8, 9, 11};

	wdt_top #(.LSO_DIV(DIV)) dut_u (
		.sys_clk_i              (sys_clk_i),
		.sys_rst_i              (sys_rst_i),
		.opt_byte_i             (opt),
		.cpu_addr_i             (addr),
		.cpu_wr_i               (wr),
		.cpu_rd_i               (rd),
		.cpu_bit_op_i           (bop),
		.cpu_wdata_i            (wdat),
		.halt_i                 (halt),
		.stop_i                 (stp),
		.snooze_i               (snz),
		.cause_clr_i            (cclr),
		.cpu_rdata_o            (rdat),
		.wdg_reset_req_o        (req),
		.interval_irq_o         (irq),
		.reset_cause_register_o (cause)
	);

	// 20 MHz system clock
	always #25 sys_clk_i = ~sys_clk_i;

	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one-cycle access; returns just after the edge that takes it,
	// so the registered answer is already visible
	task automatic acc(input logic w, input logic [19:0] a,
		input logic [7:0] d, input logic b);
		@(posedge sys_clk_i);
		wr   <= w;
		rd   <= !w;
		addr <= a;
		wdat <= d;
		bop  <= b;
		@(posedge sys_clk_i);
		wr   <= 1'b0;
		rd   <= 1'b0;
		bop  <= 1'b0;
		#1;
	endtask

	// bounded wait for the reset request (s=0) or the irq (s=1)
	task automatic wt(input int s, input int max, output int cnt,
		output logic found);
		cnt = 0;
		found = 1'b0;
		while (!found && cnt < max) begin
			@(posedge sys_clk_i);
			#1;
			cnt++;
			found = (s == 0) ? (req === 1'b1) : (irq === 1'b1);
		end
	endtask

	// new option strap is sampled in ST_LOAD, entered after a system reset or a watchdog reset request
	task automatic rst(input logic [7:0] o);
		@(posedge sys_clk_i);
		opt       <= o;
		sys_rst_i <= 1'b1;
		repeat (20) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask

	// hang guard, well above the longest expected run
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		mismatches++;
		end_sim();
	end

	initial begin
		// register map and read values, irq on, full window, shortest ovf
		rst(8'hf1);
		check("cause after reset", cause, 8'h00);
		acc(1'b0, `WDT_KEY_ADDR, 8'h00, 1'b0);
		check("key read run", rdat, 8'h9a);
		acc(1'b0, `WDT_OPT_ADDR, 8'h00, 1'b0);
		check("option read", rdat, 8'hf1);
		acc(1'b1, `WDT_OPT_ADDR, 8'h00, 1'b0);
		check("option write req", {7'h0, req}, 8'h00);
		acc(1'b0, `WDT_OPT_ADDR, 8'h00, 1'b0);
		check("option read only", rdat, 8'hf1);
		acc(1'b1, 20'h00001, 8'h55, 1'b0);
		check("unmapped write", {7'h0, req}, 8'h00);
		acc(1'b0, 20'h00001, 8'h00, 1'b0);
		check("unmapped read", rdat, 8'h00);

		// free-running overflow, then irq and overflow timed from re-init
		wt(0, 600, n, hit);
		check("overflow req", {7'h0, hit}, 8'h01);
		check("cause flag", cause, 8'h10);
		wt(1, 450, n1, hit);
		check("irq seen", {7'h0, hit}, 8'h01);
		check("irq at 75pct", 8'(n1 >= 376 && n1 <= 400), 8'h01);
		wt(0, 200, n, hit);
		check("count on after irq", {7'h0, hit}, 8'h01);
		t = n + n1;
		check("ovf 2^6", 8'(t >= 496 && t <= 520), 8'h01);
		@(posedge sys_clk_i);
		cclr <= 1'b1;
		@(posedge sys_clk_i);
		cclr <= 1'b0;
		#1;
		check("cause cleared", cause, 8'h00);

		// wrong key and bit-level access both trip the request
		acc(1'b1, `WDT_KEY_ADDR, 8'h55, 1'b0);
		check("bad key req", {7'h0, req}, 8'h01);
		check("bad key cause", cause, 8'h10);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b1);
		check("bit op req", {7'h0, req}, 8'h01);
		acc(1'b0, `WDT_KEY_ADDR, 8'h00, 1'b0);
		check("key read not written", rdat, 8'h9a);

		// remaining short overflow codes, timed from reset release
		for (int c = 1; c < 5; c++) begin
			rst(8'h71 | 8'(c << 1));
			t = (1 << ex[c - 1]) * DIV;
			wt(0, t + 50, n, hit);
			check("ovf code", 8'(n >= t - 16 && n <= t + 8), 8'h01);
		end

		// 50 pct window: first write free, early second write refused
		rst(8'hb1);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("first key", {7'h0, req}, 8'h00);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("closed window", {7'h0, req}, 8'h01);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("first after wdg rst", {7'h0, req}, 8'h00);
		repeat (300) @(posedge sys_clk_i);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("open window", {7'h0, req}, 8'h00);
		wt(0, 490, n, hit);
		check("cleared no ovf", {7'h0, hit}, 8'h00);
		// late restart a few ticks before overflow must still save it
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("late key", {7'h0, req}, 8'h00);
		// quiet span after a clear beyond the irq point: no stray irq
		wt(1, 40, n, hit);
		check("no irq after late clear", {7'h0, hit}, 8'h00);
		wt(0, 400, n, hit);
		check("late key no ovf", {7'h0, hit}, 8'h00);

		// 75 pct window: only the first quarter of the period is closed
		rst(8'h51);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("first key 75", {7'h0, req}, 8'h00);
		repeat (100) @(posedge sys_clk_i);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("closed quarter", {7'h0, req}, 8'h01);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("first after rst 75", {7'h0, req}, 8'h00);
		repeat (160) @(posedge sys_clk_i);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("open after quarter", {7'h0, req}, 8'h00);

		// run option clear: counter stays stopped
		rst(8'h61);
		acc(1'b0, `WDT_KEY_ADDR, 8'h00, 1'b0);
		check("key read stopped", rdat, 8'h1a);
		wt(0, 700, n, hit);
		check("no count", {7'h0, hit}, 8'h00);

		// standby bit clear: window fully open, standby freezes counting
		rst(8'h30);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		acc(1'b1, `WDT_KEY_ADDR, `WDT_KEY_VALUE, 1'b0);
		check("window forced open", {7'h0, req}, 8'h00);
		repeat (300) @(posedge sys_clk_i);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk_i);
			{halt, stp, snz} <= 3'b001 << i;
			wt(0, 700, n, hit);
			check("standby freeze", {7'h0, hit}, 8'h00);
		end
		@(posedge sys_clk_i);
		{halt, stp, snz} <= 3'b000;
		wt(0, 600, n, hit);
		check("halt exit clears", 8'(n >= 496 && n <= 520), 8'h01);

		// standby bit set: counting goes on through halt
		rst(8'h71);
		@(posedge sys_clk_i);
		halt <= 1'b1;
		wt(0, 600, n, hit);
		check("standby counts", {7'h0, hit}, 8'h01);
		@(posedge sys_clk_i);
		halt <= 1'b0;
		end_sim();
	end
endmodule
